// ===== rtl/bet_tester.sv
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module bet_tester import bet_pkg::*; (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                nrst,
	// Register port
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	// Channel fabric data
	output logic      [WORD_W-1:0]   tx_data,
	input  wire logic [WORD_W-1:0]   rx_data,
	input  wire logic                rx_valid,
	// Channel control
	output logic      [2:0]          tx_loopback_sel,
	output logic                     chan_reset,
	// Asynchronous status
	input  wire logic                pll_lock,
	input  wire logic                tx_user_clock,
	input  wire logic                tx_user_fabric_clock,
	input  wire logic                rx_user_clock,
	input  wire logic                rx_user_fabric_clock,
	// Reconfiguration port
	output logic                     dynamic_reconfig_port_en,
	output logic                     dynamic_reconfig_port_we,
	output logic      [DCFG_AW-1:0]  dynamic_reconfig_port_addr,
	output logic      [DCFG_DW-1:0]  dynamic_reconfig_port_wdata,
	// Spare channel ports
	output logic      [PORT_W-1:0]   port_ctrl,
	input  wire logic [PORT_W-1:0]   port_stat
);
	logic [1:0]          rst_sync_ff;
	logic                rst_n;
	logic [31:0]         ctrl_ff;
	bet_pat_t            tx_pat;
	bet_pat_t            rx_pat;
	bet_loop_t           loop_mode;
	logic                wr_ctrl;
	logic                rd_hit;
	logic [5:0]          rst_cnt_ff;
	logic                chan_rst_ff;
	logic                inject_ff;
	logic                clear_ff;
	logic [WORD_W-1:0]   gen_ff;
	logic [WORD_W-1:0]   fifo_ff [2];
	logic [WORD_W-1:0]   tx_ff;
	logic [WORD_W-1:0]   nxt_tx;
	logic [WORD_W-1:0]   rx_in_ff;
	logic                rx_vld_ff;
	logic [WORD_W-1:0]   ref_ff;
	logic [WORD_W-1:0]   expect_w;
	logic [WORD_W-1:0]   diff_w;
	bet_chk_t            chk_ff;
	logic [3:0]          good_ff;
	logic [3:0]          bad_ff;
	logic [CNT_W-1:0]    bits_ff;
	logic [CNT_W-1:0]    errs_ff;
	logic [15:0]         bits_snap_ff;
	logic [15:0]         errs_snap_ff;
	logic [2:0]          pll_sync_ff;
	logic                pll_ff;
	logic [2:0]          ck_sync_ff [4];
	logic [3:0]          ck_lvl_ff;
	logic [7:0]          ck_cnt_ff [4];
	logic [7:0]          ck_mhz_ff [4];
	logic [3:0]          ck_raw;
	logic [7:0]          win_ff;
	logic [DCFG_DW-1:0]  dcfg_mem [2**DCFG_AW];
	logic                dcfg_hit;
	logic                dcfg_en_ff;
	logic                dcfg_we_ff;
	logic [DCFG_AW-1:0]  dcfg_addr_ff;
	logic [DCFG_DW-1:0]  dcfg_wdata_ff;
	logic [PORT_W-1:0]   port_ctrl_ff;
	logic [2:0]          loop_sel_ff;
	logic [31:0]         rdata_ff;
	logic [31:0]         nxt_rdata;

	// Next word of a pattern, 32 serial steps at once; bit 0 is oldest
	function automatic logic [WORD_W-1:0] pat_next(input logic [WORD_W-1:0] w,
		input bet_pat_t p);
		logic [2*WORD_W-1:0] s;
		int                  a;
		int                  b;
		logic                inv;
		s   = {{WORD_W{1'b0}}, w};
		a   = 31;
		b   = 28;
		inv = 1'b0;
		unique case (p)
			PAT_PRBS7: begin
				a = 7;
				b = 6;
			end
			PAT_PRBS15: begin
				a = 15;
				b = 14;
			end
			PAT_PRBS23: begin
				a = 23;
				b = 18;
			end
			PAT_PRBS31: begin
				a = 31;
				b = 28;
			end
			PAT_CLK2X: begin
				a   = 1;
				inv = 1'b1;
			end
			PAT_CLK10X: begin
				a   = 5;
				inv = 1'b1;
			end
			default: begin
				a = 31;
				b = 28;
			end
		endcase
		for (int i = WORD_W; i < 2 * WORD_W; i++) begin
			s[i] = inv ? ~s[i-a] : (s[i-a] ^ s[i-b]);
		end
		return s[2*WORD_W-1:WORD_W];
	endfunction

	function automatic logic [5:0] ones(input logic [WORD_W-1:0] w);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < WORD_W; i++) begin
			n = n + {5'h00, w[i]};
		end
		return n;
	endfunction

	function automatic logic [7:0] top_bit(input logic [CNT_W-1:0] v);
		logic [7:0] k;
		k = 8'h00;
		for (int i = 0; i < CNT_W; i++) begin
			if (v[i]) begin
				k = 8'(i);
			end
		end
		return k;
	endfunction

	// Reset release
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	assign tx_pat    = bet_pat_t'(ctrl_ff[F_TX_PAT+:3]);
	assign rx_pat    = bet_pat_t'(ctrl_ff[F_RX_PAT+:3]);
	assign loop_mode = bet_loop_t'(ctrl_ff[F_LOOP+:3]);
	assign wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
	assign dcfg_hit  = (reg_addr[ADDR_W-1:DCFG_AW+2] == REG_DCFG_BASE[ADDR_W-1:DCFG_AW+2]);

	// Independent pattern selects, loop mode and polarity
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_ff <= {18'h00000, reg_wdata[F_RX_INV:0]};
		end
	end

	// Command pulses from the control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inject_ff <= 1'b0;
			clear_ff  <= 1'b0;
		end else begin
			inject_ff <= wr_ctrl && reg_wdata[F_INJECT];
			clear_ff  <= wr_ctrl && reg_wdata[F_CNT_CLR];
		end
	end

	// Channel reset stretched so the transceiver sees a clean pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt_ff  <= 6'h00;
			chan_rst_ff <= 1'b0;
		end else if (wr_ctrl && reg_wdata[F_CHAN_RST]) begin
			rst_cnt_ff  <= 6'(CHAN_RST_CYC - 1);
			chan_rst_ff <= 1'b1;
		end else if (rst_cnt_ff != 6'h00) begin
			rst_cnt_ff  <= rst_cnt_ff - 6'h01;
		end else begin
			chan_rst_ff <= 1'b0;
		end
	end

	// Transmit generator, restarted by channel reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_ff <= GEN_SEED;
		end else if (chan_rst_ff) begin
			gen_ff <= GEN_SEED;
		end else if (wr_ctrl && reg_wdata[F_TX_PAT+:3] != ctrl_ff[F_TX_PAT+:3]) begin
			// New pattern could inherit an all-zero history and stick
			gen_ff <= GEN_SEED;
		end else begin
			gen_ff <= pat_next(gen_ff, tx_pat);
		end
	end

	// Shallow fabric FIFO for far fabric loopback
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_ff[0] <= '0;
			fifo_ff[1] <= '0;
		end else if (chan_rst_ff) begin
			fifo_ff[0] <= '0;
			fifo_ff[1] <= '0;
		end else begin
			fifo_ff[0] <= rx_data;
			fifo_ff[1] <= fifo_ff[0];
		end
	end

	always_comb begin
		nxt_tx = (loop_mode == LOOP_FAR_FABRIC) ? fifo_ff[1] : gen_ff;
		nxt_tx[0] = nxt_tx[0] ^ inject_ff;
		nxt_tx = nxt_tx ^ {WORD_W{ctrl_ff[F_TX_INV]}};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ff <= '0;
		end else begin
			tx_ff <= nxt_tx;
		end
	end

	// Fabric loopback is ours; the transceiver sees it as no loopback
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_sel_ff <= 3'(LOOP_NONE);
		end else if (loop_mode == LOOP_FAR_FABRIC) begin
			loop_sel_ff <= 3'(LOOP_NONE);
		end else begin
			loop_sel_ff <= 3'(loop_mode);
		end
	end

	// Receive capture with polarity applied before checking
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_in_ff  <= '0;
			rx_vld_ff <= 1'b0;
		end else begin
			rx_in_ff  <= rx_data ^ {WORD_W{ctrl_ff[F_RX_INV]}};
			rx_vld_ff <= rx_valid && !chan_rst_ff;
		end
	end

	assign expect_w = pat_next(ref_ff, rx_pat);
	assign diff_w   = expect_w ^ rx_in_ff;

	// Checker: hunt seeds from line data, lock runs the local copy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chk_ff  <= CHK_HUNT;
			ref_ff  <= '0;
			good_ff <= 4'h0;
			bad_ff  <= 4'h0;
		end else if (chan_rst_ff || wr_ctrl) begin
			chk_ff  <= CHK_HUNT;
			good_ff <= 4'h0;
			bad_ff  <= 4'h0;
		end else if (rx_vld_ff) begin
			unique case (chk_ff)
				CHK_HUNT: begin
					ref_ff <= rx_in_ff;
					bad_ff <= 4'h0;
					// All-zero data would fake a lock on any PRBS
					if (diff_w == '0 && rx_in_ff != '0) begin
						good_ff <= good_ff + 4'h1;
						if (good_ff == 4'(SYNC_GOOD - 1)) begin
							chk_ff <= CHK_LOCK;
						end
					end else begin
						good_ff <= 4'h0;
					end
				end
				CHK_LOCK: begin
					ref_ff <= expect_w;
					good_ff <= 4'h0;
					if (diff_w == '0) begin
						bad_ff <= 4'h0;
					end else if (bad_ff == 4'(SYNC_LOSS - 1)) begin
						chk_ff <= CHK_HUNT;
						bad_ff <= 4'h0;
					end else begin
						bad_ff <= bad_ff + 4'h1;
					end
				end
			endcase
		end
	end

	// Counters; clearing them leaves the channel alone, but the control write sends the checker back to hunt
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bits_ff <= '0;
		end else if (clear_ff) begin
			bits_ff <= '0;
		end else if (rx_vld_ff) begin
			bits_ff <= bits_ff + CNT_W'(WORD_W);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			errs_ff <= '0;
		end else if (clear_ff) begin
			errs_ff <= '0;
		end else if (rx_vld_ff && chk_ff == CHK_LOCK) begin
			errs_ff <= errs_ff + CNT_W'(ones(diff_w));
		end
	end

	// Pll lock and clocks come from outside: three flops, settle on agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_sync_ff <= 3'b000;
			pll_ff      <= 1'b0;
		end else begin
			pll_sync_ff <= {pll_sync_ff[1:0], pll_lock};
			if (pll_sync_ff[1] == pll_sync_ff[2]) begin
				pll_ff <= pll_sync_ff[2];
			end
		end
	end

	assign ck_raw = {rx_user_fabric_clock, rx_user_clock,
		tx_user_fabric_clock, tx_user_clock};

	// Edge count over a 1 us window gives MHz; only clocks below a quarter
	// of the system rate read true
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			win_ff    <= 8'h00;
			ck_lvl_ff <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				ck_sync_ff[i] <= 3'b000;
				ck_cnt_ff[i]  <= 8'h00;
				ck_mhz_ff[i]  <= 8'h00;
			end
		end else begin
			win_ff <= (win_ff == 8'(MEAS_WIN_CYC - 1)) ? 8'h00 : win_ff + 8'h01;
			for (int i = 0; i < 4; i++) begin
				ck_sync_ff[i] <= {ck_sync_ff[i][1:0], ck_raw[i]};
				if (ck_sync_ff[i][1] == ck_sync_ff[i][2]) begin
					ck_lvl_ff[i] <= ck_sync_ff[i][2];
				end
				if (win_ff == 8'(MEAS_WIN_CYC - 1)) begin
					ck_mhz_ff[i] <= ck_cnt_ff[i];
					ck_cnt_ff[i] <= 8'h00;
				end else if (ck_sync_ff[i][1] == ck_sync_ff[i][2] &&
					ck_sync_ff[i][2] && !ck_lvl_ff[i]) begin
					ck_cnt_ff[i] <= ck_cnt_ff[i] + 8'h01;
				end
			end
		end
	end

	// Reconfiguration writes go straight out; shadow answers reads
	always_ff @(posedge clk) begin
		if (reg_wr && dcfg_hit) begin
			dcfg_mem[reg_addr[DCFG_AW+1:2]] <= reg_wdata[DCFG_DW-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dcfg_en_ff    <= 1'b0;
			dcfg_we_ff    <= 1'b0;
			dcfg_addr_ff  <= '0;
			dcfg_wdata_ff <= '0;
		end else begin
			dcfg_en_ff <= reg_wr && dcfg_hit;
			dcfg_we_ff <= reg_wr && dcfg_hit;
			if (reg_wr && dcfg_hit) begin
				dcfg_addr_ff  <= reg_addr[DCFG_AW+1:2];
				dcfg_wdata_ff <= reg_wdata[DCFG_DW-1:0];
			end
		end
	end

	// Spare ports; the status group has no write path at all
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_ctrl_ff <= PORT_CTRL_RST;
		end else if (reg_wr && reg_addr == REG_PORT_CTRL) begin
			port_ctrl_ff <= reg_wdata[PORT_W-1:0];
		end
	end

	// High halves frozen on low read so a pair reads coherent
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bits_snap_ff <= 16'h0000;
			errs_snap_ff <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == REG_BITS_LO) begin
				bits_snap_ff <= bits_ff[CNT_W-1:32];
			end
			if (reg_addr == REG_ERRS_LO) begin
				errs_snap_ff <= errs_ff[CNT_W-1:32];
			end
		end
	end

	assign rd_hit = reg_rd;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (dcfg_hit) begin
			nxt_rdata = {16'h0000, dcfg_mem[reg_addr[DCFG_AW+1:2]]};
		end else begin
			unique case (reg_addr)
				REG_CTRL:      nxt_rdata = ctrl_ff;
				REG_STATUS: begin
					nxt_rdata[F_LINK]      = (chk_ff == CHK_LOCK) && pll_ff;
					nxt_rdata[F_PLL]       = pll_ff;
					nxt_rdata[F_CHAN_BUSY] = chan_rst_ff;
				end
				REG_BITS_LO:   nxt_rdata = bits_ff[31:0];
				REG_BITS_HI:   nxt_rdata = {16'h0000, bits_snap_ff};
				REG_ERRS_LO:   nxt_rdata = errs_ff[31:0];
				REG_ERRS_HI:   nxt_rdata = {16'h0000, errs_snap_ff};
				REG_RATIO: begin
					// Log2 of bits per error, coarse but cheap
					nxt_rdata[7:0]       = top_bit(bits_ff) - top_bit(errs_ff);
					nxt_rdata[F_NO_ERRS] = (errs_ff == '0);
				end
				REG_LINE_RATE: begin
					if (chk_ff == CHK_LOCK && pll_ff) begin
						nxt_rdata = 32'(ck_mhz_ff[2]) * 32'(WORD_W);
					end
				end
				REG_FREQ_TX:   nxt_rdata = {8'h00, ck_mhz_ff[1], 8'h00, ck_mhz_ff[0]};
				REG_FREQ_RX:   nxt_rdata = {8'h00, ck_mhz_ff[3], 8'h00, ck_mhz_ff[2]};
				REG_PORT_CTRL: nxt_rdata = {16'h0000, port_ctrl_ff};
				REG_PORT_STAT: nxt_rdata = {16'h0000, port_stat};
				default:       nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (rd_hit) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	assign reg_rdata                   = rdata_ff;
	assign tx_data                     = tx_ff;
	assign tx_loopback_sel             = loop_sel_ff;
	assign chan_reset                  = chan_rst_ff;
	assign dynamic_reconfig_port_en    = dcfg_en_ff;
	assign dynamic_reconfig_port_we    = dcfg_we_ff;
	assign dynamic_reconfig_port_addr  = dcfg_addr_ff;
	assign dynamic_reconfig_port_wdata = dcfg_wdata_ff;
	assign port_ctrl                   = port_ctrl_ff;
endmodule

// ===== rtl/bet_pkg.sv
// Function
// - Patterns: PRBS 7/15/23/31, clock 2x/10x
// - Separate transmit and receive pattern selects
// - Inject flips exactly one transmitted bit
// - Count every received bit until cleared
// - Count checker bit errors until cleared
// - Counter clear leaves channel running
// - Report error ratio from both counters
// - Loopback off or near coding path
// - Near analog loopback through both sublayers
// - Far analog loopback pins to pins
// - Far coding loopback via coding sublayer
// - Far fabric loopback through shallow FIFO
// - Channel reset reinitialises channel and fabric
// - Transmit polarity invert flips sent bits
// - Receive polarity invert before checking
// - Link status plus measured line rate
// - Two-state PLL lock indication
// - Measure four user clocks in MHz
// - Reconfig port writes immediate, readable back
// - Spare ports: writable ones, read-only ones
package bet_pkg;
	localparam int          WORD_W        = 32;
	localparam int          CNT_W         = 48;
	localparam int          ADDR_W        = 10;
	localparam int          DCFG_AW       = 7;
	localparam int          DCFG_DW       = 16;
	localparam int          PORT_W        = 16;
	// Register offsets
	localparam logic [9:0]  REG_CTRL      = 10'h000;
	localparam logic [9:0]  REG_STATUS    = 10'h004;
	localparam logic [9:0]  REG_BITS_LO   = 10'h008;
	localparam logic [9:0]  REG_BITS_HI   = 10'h00c;
	localparam logic [9:0]  REG_ERRS_LO   = 10'h010;
	localparam logic [9:0]  REG_ERRS_HI   = 10'h014;
	localparam logic [9:0]  REG_RATIO     = 10'h018;
	localparam logic [9:0]  REG_LINE_RATE = 10'h01c;
	localparam logic [9:0]  REG_FREQ_TX   = 10'h020;
	localparam logic [9:0]  REG_FREQ_RX   = 10'h024;
	localparam logic [9:0]  REG_PORT_CTRL = 10'h030;
	localparam logic [9:0]  REG_PORT_STAT = 10'h034;
	localparam logic [9:0]  REG_DCFG_BASE = 10'h200;
	// Control fields
	localparam int          F_TX_PAT      = 0;
	localparam int          F_RX_PAT      = 4;
	localparam int          F_LOOP        = 8;
	localparam int          F_TX_INV      = 12;
	localparam int          F_RX_INV      = 13;
	localparam int          F_CHAN_RST    = 16;
	localparam int          F_INJECT      = 17;
	localparam int          F_CNT_CLR     = 18;
	// Status and ratio register fields
	localparam int          F_LINK        = 0;
	localparam int          F_PLL         = 1;
	localparam int          F_CHAN_BUSY   = 2;
	localparam int          F_NO_ERRS     = 8;
	// Timing
	localparam int          CLK_MHZ       = 250;
	localparam int          MEAS_WIN_NS   = 1000;
	localparam int          MEAS_WIN_CYC  = MEAS_WIN_NS * CLK_MHZ / 1000;
	localparam int          CHAN_RST_NS   = 64;
	localparam int          CHAN_RST_CYC  = (CHAN_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int          SYNC_GOOD     = 8;
	localparam int          SYNC_LOSS     = 4;
	// Reset values
	localparam logic [31:0] CTRL_RST      = 32'h0000_0033;
	localparam logic [31:0] GEN_SEED      = 32'hffff_ffff;
	localparam logic [15:0] PORT_CTRL_RST = 16'h0000;

	typedef enum logic [2:0] {
		PAT_PRBS7  = 3'b000,
		PAT_PRBS15 = 3'b001,
		PAT_PRBS23 = 3'b010,
		PAT_PRBS31 = 3'b011,
		PAT_CLK2X  = 3'b100,
		PAT_CLK10X = 3'b101
	} bet_pat_t;

	typedef enum logic [2:0] {
		LOOP_NONE        = 3'b000,
		LOOP_NEAR_CODING = 3'b001,
		LOOP_NEAR_ANALOG = 3'b010,
		LOOP_FAR_ANALOG  = 3'b011,
		LOOP_FAR_CODING  = 3'b100,
		LOOP_FAR_FABRIC  = 3'b101
	} bet_loop_t;

	typedef enum logic {
		CHK_HUNT = 1'b0,
		CHK_LOCK = 1'b1
	} bet_chk_t;
endpackage

// ===== test/bet_link_model.sv
`timescale 1ns/100ps
module bet_link_model import bet_pkg::*; (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// Tester transmit side
	input  wire logic [WORD_W-1:0] tx_data,
	input  wire logic              chan_reset,
	// Bench command: flip bit 0 of one word
	input  wire logic              hit,
	// Returned words
	output logic      [WORD_W-1:0] rx_data,
	output logic                   rx_valid
);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_data  <= 32'h0;
			rx_valid <= 1'b0;
		end else if (chan_reset) begin
			// Churn so a stale word never looks valid
			rx_valid <= 1'b0;
			rx_data  <= ~rx_data;
		end else begin
			rx_valid <= 1'b1;
			rx_data  <= tx_data ^ {31'h0, hit};
		end
	end
endmodule

// ===== test/bet_tester_monitor.sv
`timescale 1ns/100ps
module bet_tester_monitor import bet_pkg::*; (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// Register port
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic [31:0]        reg_rdata,
	// Channel control
	input  wire logic [2:0]         tx_loopback_sel,
	input  wire logic               chan_reset,
	// Reconfiguration port
	input  wire logic               dynamic_reconfig_port_en,
	input  wire logic               dynamic_reconfig_port_we,
	input  wire logic [DCFG_AW-1:0] dynamic_reconfig_port_addr,
	input  wire logic [DCFG_DW-1:0] dynamic_reconfig_port_wdata,
	// Spare ports
	input  wire logic [PORT_W-1:0]  port_ctrl,
	input  wire logic [PORT_W-1:0]  port_stat
);
	logic [ADDR_W-1:0] addr_q_ff;
	logic [31:0]       wd_q_ff;
	logic [31:0]       wd_q2_ff;
	logic [4:0]        rlen_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Copies of the last request, so checks compare exact fields
	always_ff @(posedge clk) begin
		addr_q_ff <= reg_addr;
		wd_q_ff   <= reg_wdata;
		wd_q2_ff  <= wd_q_ff;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rlen_ff <= 5'h0;
		else if (chan_reset)
			rlen_ff <= rlen_ff + 5'h1;
		else
			rlen_ff <= 5'h0;
	end

	chk_dcfg_write: assert property (reg_wr && reg_addr[9] |=>
		dynamic_reconfig_port_en && dynamic_reconfig_port_we &&
		dynamic_reconfig_port_addr == addr_q_ff[8:2] &&
		dynamic_reconfig_port_wdata == wd_q_ff[15:0]) else $error("reconfig write lost");
	chk_dcfg_quiet: assert property (!(reg_wr && reg_addr[9]) |=>
		!dynamic_reconfig_port_en) else $error("reconfig strobe without write");
	chk_port_write: assert property (reg_wr && reg_addr == REG_PORT_CTRL |=>
		port_ctrl == wd_q_ff[15:0]) else $error("spare port not written");
	chk_port_hold: assert property (!(reg_wr && reg_addr == REG_PORT_CTRL) |=>
		$stable(port_ctrl)) else $error("spare port moved");
	chk_stat_read: assert property (reg_rd && reg_addr == REG_PORT_STAT |=>
		reg_rdata[15:0] == $past(port_stat)) else $error("spare status read wrong");
	chk_reset_start: assert property (reg_wr && reg_addr == REG_CTRL &&
		reg_wdata[F_CHAN_RST] |=> chan_reset) else $error("channel reset missing");
	chk_reset_len: assert property ($fell(chan_reset) |->
		rlen_ff == 5'h10) else $error("channel reset length wrong");
	chk_reset_max: assert property (chan_reset |->
		rlen_ff < 5'h10) else $error("channel reset too long");
	chk_loop_sel: assert property (reg_wr && reg_addr == REG_CTRL |-> ##2
		tx_loopback_sel == ((wd_q2_ff[10:8] == 3'h5) ? 3'h0 : wd_q2_ff[10:8]))
		else $error("loopback code wrong");
	chk_loop_hold: assert property (!(reg_wr && reg_addr == REG_CTRL) ##1 1'b1 |=>
		$stable(tx_loopback_sel)) else $error("loopback moved");
endmodule

bind bet_tester bet_tester_monitor u_mon (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.tx_loopback_sel(tx_loopback_sel), .chan_reset(chan_reset),
	.dynamic_reconfig_port_en(dynamic_reconfig_port_en),
	.dynamic_reconfig_port_we(dynamic_reconfig_port_we),
	.dynamic_reconfig_port_addr(dynamic_reconfig_port_addr),
	.dynamic_reconfig_port_wdata(dynamic_reconfig_port_wdata),
	.port_ctrl(port_ctrl), .port_stat(port_stat));

// ===== test/tb.sv
`timescale 1ns/100ps
module tb import bet_pkg::*;;
	logic        clk, nrst, reg_wr, reg_rd, pll_lock, hit, mon_on, rx_valid;
	logic        tx_user_clock = 1'b0, tx_user_fabric_clock = 1'b0;
	logic        rx_user_clock = 1'b0, rx_user_fabric_clock = 1'b0;
	logic        chan_reset, d_en, d_we;
	logic [9:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, tx_data, rx_data, prev_tx, v;
	logic [2:0]  loop_sel;
	logic [6:0]  d_addr;
	logic [15:0] d_wd, port_ctrl, port_stat;
	logic [63:0] x;
	int          mismatches, n_tests, viol, ncy, cyc;

	bet_tester u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
		.rx_data(rx_data), .rx_valid(rx_valid), .tx_loopback_sel(loop_sel),
		.chan_reset(chan_reset), .pll_lock(pll_lock), .tx_user_clock(tx_user_clock),
		.tx_user_fabric_clock(tx_user_fabric_clock), .rx_user_clock(rx_user_clock),
		.rx_user_fabric_clock(rx_user_fabric_clock), .dynamic_reconfig_port_en(d_en),
		.dynamic_reconfig_port_we(d_we), .dynamic_reconfig_port_addr(d_addr),
		.dynamic_reconfig_port_wdata(d_wd), .port_ctrl(port_ctrl), .port_stat(port_stat));
	bet_link_model u_link (.clk(clk), .nrst(nrst), .tx_data(tx_data),
		.chan_reset(chan_reset), .hit(hit), .rx_data(rx_data), .rx_valid(rx_valid));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Unrelated rates; sampling races cost at most one count
	initial forever #12.5 tx_user_clock = ~tx_user_clock;
	initial forever #25 tx_user_fabric_clock = ~tx_user_fabric_clock;
	initial forever #10 rx_user_clock = ~rx_user_clock;
	initial forever #20 rx_user_fabric_clock = ~rx_user_fabric_clock;

	// Pin-side check of the order 31 recurrence on each word
	assign x = {tx_data, prev_tx};
	always @(posedge clk) begin
		prev_tx <= tx_data;
		viol <= mon_on ? viol + $countones(tx_data ^ x[32:1] ^ x[35:4]) : 0;
		ncy <= mon_on ? ncy + 1 : 0;
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rng(input logic [31:0] s, input logic [31:0] lo, input logic [31:0] hi);
		chk(32'(s >= lo && s <= hi), 32'h1);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [9:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rc(input logic [9:0] a, input logic [31:0] e);
		rd(a, v);
		chk(v, e);
	endtask
	task automatic run_pat(input logic [31:0] c);
		wr(REG_CTRL, c);
		wt(60);
		wr(REG_CTRL, c | 32'h40000);
		rd(REG_BITS_LO, v);
		chk(32'(v < 256), 32'h1);
		wt(60);
		rc(REG_ERRS_LO, 32'h0);
		rd(REG_BITS_LO, v);
		chk(32'(v > 0 && v[4:0] == 5'h0), 32'h1);
		rd(REG_STATUS, v);
		chk(32'(v[1:0]), 32'h3);
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		{nrst, reg_wr, reg_rd, hit, mon_on} = 5'h0;
		{reg_addr, reg_wdata, port_stat} = 58'h0;
		pll_lock = 1'b1;
		{mismatches, n_tests} = 64'h0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rc(REG_CTRL, CTRL_RST);
		rc(REG_PORT_CTRL, 32'h0);
		rc(10'h040, 32'h0);
		wr(REG_PORT_CTRL, 32'hbeef);
		chk(32'(port_ctrl), 32'hbeef);
		rc(REG_PORT_CTRL, 32'hbeef);
		@(posedge clk) port_stat <= 16'h5a3c;
		wr(REG_PORT_STAT, 32'hffff);
		rc(REG_PORT_STAT, 32'h5a3c);
		tdone("ports");
		for (int i = 0; i < 4; i++) begin
			wr(REG_DCFG_BASE + 10'(4 * i), 32'ha000 + i);
			chk(32'({d_en, d_we, d_addr, d_wd}), 32'({2'b11, 7'(i), 16'ha000 + 16'(i)}));
		end
		for (int i = 0; i < 4; i++)
			rc(REG_DCFG_BASE + 10'(4 * i), 32'ha000 + i);
		tdone("reconfig");
		for (int l = 0; l < 6; l++) begin
			wr(REG_CTRL, 32'h33 | (l << 8));
			wt(1);
			chk(32'(loop_sel), (l == 5) ? 0 : l);
			rc(REG_CTRL, 32'h33 | (l << 8));
		end
		tdone("loopback");
		for (int p = 0; p < 6; p++)
			run_pat(32'(p * 17));
		wr(REG_CTRL, 32'h10);
		wt(60);
		rd(REG_STATUS, v);
		chk(32'(v[0]), 32'h0);
		rc(REG_CTRL, 32'h10);
		tdone("patterns");
		run_pat(32'h3033);
		wr(REG_CTRL, 32'h2033);
		wt(60);
		rd(REG_STATUS, v);
		chk(32'(v[0]), 32'h0);
		tdone("polarity");
		run_pat(32'h33);
		rd(REG_FREQ_TX, v);
		rng(v[7:0], 39, 41);
		rng(v[23:16], 19, 21);
		rd(REG_FREQ_RX, v);
		rng(v[7:0], 49, 51);
		rng(v[23:16], 24, 26);
		rd(REG_LINE_RATE, v);
		rng(v, 1568, 1632);
		tdone("clocks");
		@(posedge clk) hit <= 1'b1;
		@(posedge clk) hit <= 1'b0;
		wt(10);
		rc(REG_ERRS_LO, 32'h1);
		rc(REG_ERRS_HI, 32'h0);
		rd(REG_RATIO, v);
		chk(32'(v[8]), 32'h0);
		rng(v[7:0], 10, 12);
		wr(REG_CTRL, 32'h40033);
		wt(5);
		rc(REG_ERRS_LO, 32'h0);
		rd(REG_RATIO, v);
		chk(32'(v[8]), 32'h1);
		tdone("errors");
		wt(10);
		@(posedge clk) mon_on <= 1'b1;
		wt(20);
		chk(32'(viol), 32'h0);
		wr(REG_CTRL, 32'h20033);
		wt(5);
		chk(32'(viol), 32'h3);
		@(posedge clk) mon_on <= 1'b0;
		wr(REG_CTRL, 32'h1033);
		wt(5);
		@(posedge clk) mon_on <= 1'b1;
		wt(10);
		chk(32'(viol), 32'(32 * ncy));
		@(posedge clk) mon_on <= 1'b0;
		tdone("pins");
		wr(REG_CTRL, 32'h10033);
		rd(REG_STATUS, v);
		chk(32'(v[2]), 32'h1);
		wt(30);
		rd(REG_STATUS, v);
		chk(32'(v[2]), 32'h0);
		tdone("chanreset");
		@(posedge clk) pll_lock <= 1'b0;
		wt(10);
		rd(REG_STATUS, v);
		chk(32'(v[1:0]), 32'h0);
		rc(REG_LINE_RATE, 32'h0);
		@(posedge clk) pll_lock <= 1'b1;
		wt(10);
		rd(REG_STATUS, v);
		chk(32'(v[1]), 32'h1);
		tdone("pll");
		final_report();
	end
endmodule
